// ---- verilog/irl_link_ctrl.sv ----
// Control and fault logic of the isolated differential line transceiver.
`timescale 1ns/1ps
module irl_link_ctrl (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Host logic pins.
  input wire logic tx_data_in,
  input wire logic tx_drive_enable,
  input wire logic rx_out_gate_n_fault_in,
  output logic rx_out_gate_n_fault_out,
  output logic rx_out_gate_n_fault_oe,
  output logic rx_data_out,
  output logic rx_data_oe,
  // Isolated side pins.
  output logic isolated_rx_copy,
  input wire logic edge_rate_sel_n,
  output logic line_tx_out,
  output logic line_tx_oe,
  output logic line_slow_slew,
  input wire logic line_rx_in,
  input wire logic line_rx_open_short,
  // Fault sources.
  input wire logic host_supply_low,
  input wire logic iso_supply_low,
  input wire logic thermal_shutdown,
  input wire logic barrier_fail
);

  // ----------------------------------------------------------------
  // Sampler ticks
  // ----------------------------------------------------------------
  // Free-running divider; its ticks bear no relation to the data edges.
  logic [irl_pkg::SAMPLE_CW-1:0] samp_cnt_r;
  logic host_tick;
  logic iso_tick;

  always_ff @(posedge clk) begin
    if (!rstn || samp_cnt_r == irl_pkg::SAMPLE_LAST) begin
      samp_cnt_r <= '0;
    end else begin
      samp_cnt_r <= samp_cnt_r + 1'b1;
    end
  end
  assign host_tick = (samp_cnt_r == '0);
  assign iso_tick = (samp_cnt_r == irl_pkg::ISO_PHASE);

  // ----------------------------------------------------------------
  // Link state and start-up
  // ----------------------------------------------------------------
  // Any hard source blocks the barrier; line opens and shorts are no source.
  logic src_any;
  irl_pkg::irl_link_t link_r;
  logic [irl_pkg::CNT_W-1:0] start_cnt_r;

  assign src_any = host_supply_low || iso_supply_low || thermal_shutdown;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      link_r <= irl_pkg::IRL_DOWN;
    end else if (src_any) begin
      link_r <= irl_pkg::IRL_DOWN;
    end else begin
      case (link_r)
        // Sources gone: begin the start-up wait.
        irl_pkg::IRL_DOWN: begin
          link_r <= irl_pkg::IRL_START;
        end
        // Resume once the least start-up time has passed.
        irl_pkg::IRL_START: begin
          if (start_cnt_r == irl_pkg::CNT_W'(irl_pkg::START_CYC - 1)) begin
            link_r <= irl_pkg::IRL_UP;
          end
        end
        irl_pkg::IRL_UP: begin
          link_r <= irl_pkg::IRL_UP;
        end
        default: begin
          link_r <= irl_pkg::IRL_DOWN;
        end
      endcase
    end
  end

  // Start-up counter runs only in the start state.
  always_ff @(posedge clk) begin
    if (!rstn || link_r != irl_pkg::IRL_START) begin
      start_cnt_r <= '0;
    end else begin
      start_cnt_r <= start_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Transmit direction
  // ----------------------------------------------------------------
  // The sampler holds a frame until the buffer takes it, so a full buffer
  // stalls sampling rather than silently losing edges.
  logic comm_on;
  logic samp_vld_r;
  logic [irl_pkg::FRAME_W-1:0] samp_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [irl_pkg::FRAME_W-1:0] fifo_out_data;
  logic [irl_pkg::FRAME_W-1:0] iso_frame_r;
  logic [irl_pkg::FRAME_W-1:0] tx_dly;
  logic de_dly;

  assign comm_on = (link_r == irl_pkg::IRL_UP) && !barrier_fail;

  always_ff @(posedge clk) begin
    if (!rstn || !comm_on) begin
      samp_vld_r <= 1'b0;
      samp_r <= '0;
    end else if (host_tick && (!samp_vld_r || fifo_in_ready)) begin
      samp_vld_r <= 1'b1;
      samp_r <= {tx_drive_enable, tx_data_in};
    end else if (fifo_in_ready) begin
      samp_vld_r <= 1'b0;
    end
  end

  irl_fifo #(
    .WIDTH(irl_pkg::FRAME_W),
    .DEPTH(irl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .flush(!comm_on),
    .in_valid(samp_vld_r),
    .in_ready(fifo_in_ready),
    .in_data(samp_r),
    .out_valid(fifo_out_valid),
    .out_ready(iso_tick),
    .out_data(fifo_out_data)
  );
  assign fifo_pop = fifo_out_valid && iso_tick;

  // Isolated side decodes one frame per isolated tick.
  always_ff @(posedge clk) begin
    if (!rstn || !comm_on) begin
      iso_frame_r <= '0;
    end else if (fifo_pop) begin
      iso_frame_r <= fifo_out_data;
    end
  end

  irl_dly #(
    .WIDTH(irl_pkg::FRAME_W),
    .DEPTH(irl_pkg::TX_DLY_CYC),
    .RST('0)
  ) u_tx_dly (
    .clk(clk),
    .rstn(rstn),
    .din(iso_frame_r),
    .dout(tx_dly)
  );

  irl_dly #(
    .WIDTH(1),
    .DEPTH(irl_pkg::DE_EXTRA_CYC),
    .RST(1'b0)
  ) u_de_dly (
    .clk(clk),
    .rstn(rstn),
    .din(tx_dly[1]),
    .dout(de_dly)
  );

  // thermal or any fault releases line
  assign line_tx_oe = de_dly && comm_on && !thermal_shutdown;
  assign line_tx_out = tx_dly[0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      line_slow_slew <= 1'b0;
    end else begin
      line_slow_slew <= !edge_rate_sel_n;
    end
  end

  // ----------------------------------------------------------------
  // Receive direction
  // ----------------------------------------------------------------
  // A fixed receiver offset makes an open or shorted pair read high.
  logic rx_level;
  logic [1:0] rx_frame_r;
  logic [1:0] rx_dly;
  logic rx_host_r;

  assign rx_level = line_rx_open_short ? irl_pkg::LINE_IDLE : line_rx_in;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      isolated_rx_copy <= irl_pkg::LINE_IDLE;
    end else begin
      isolated_rx_copy <= rx_level;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_frame_r <= {1'b0, irl_pkg::LINE_IDLE};
    end else begin
      rx_frame_r <= {iso_tick && comm_on, rx_level};
    end
  end

  irl_dly #(
    .WIDTH(2),
    .DEPTH(irl_pkg::DATA_DLY_CYC),
    .RST({1'b0, irl_pkg::LINE_IDLE})
  ) u_rx_dly (
    .clk(clk),
    .rstn(rstn),
    .din(rx_frame_r),
    .dout(rx_dly)
  );

  // Host side keeps the last received level.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_host_r <= irl_pkg::LINE_IDLE;
    end else if (rx_dly[1]) begin
      rx_host_r <= rx_dly[0];
    end
  end

  // ----------------------------------------------------------------
  // Time-out and fault indication
  // ----------------------------------------------------------------
  logic [irl_pkg::CNT_W-1:0] gap_cnt_r;
  logic timeout;
  logic fault_r;

  always_ff @(posedge clk) begin
    if (!rstn || rx_dly[1]) begin
      gap_cnt_r <= '0;
    end else if (gap_cnt_r != irl_pkg::CNT_W'(irl_pkg::TOF_CYC)) begin
      gap_cnt_r <= gap_cnt_r + 1'b1;
    end
  end
  assign timeout = (gap_cnt_r == irl_pkg::CNT_W'(irl_pkg::TOF_CYC));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      fault_r <= 1'b1;
    end else if (host_tick) begin
      fault_r <= src_any || timeout || (link_r != irl_pkg::IRL_UP);
    end
  end

  // weak fault level on gate pin
  assign rx_out_gate_n_fault_out = fault_r;
  assign rx_out_gate_n_fault_oe = 1'b1;

  // output enabled only with gate low
  assign rx_data_oe = !rx_out_gate_n_fault_in;
  assign rx_data_out = fault_r ? 1'b1 : rx_host_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int THERM_WAIT = 6;

  a_rx_gate_hiz: assert property (@(posedge clk) disable iff (!rstn)
    rx_out_gate_n_fault_in |-> !rx_data_oe) else $error("receive output driven with gate high");
  a_copy_follows: assert property (@(posedge clk) disable iff (!rstn)
    ##1 isolated_rx_copy == $past(rx_level)) else $error("isolated copy not following line");
  a_slow_slew: assert property (@(posedge clk) disable iff (!rstn)
    !edge_rate_sel_n |=> line_slow_slew) else $error("slow slew not selected");
  a_fast_slew: assert property (@(posedge clk) disable iff (!rstn)
    edge_rate_sel_n |=> !line_slow_slew) else $error("fast edges not selected");
  a_fault_high: assert property (@(posedge clk) disable iff (!rstn)
    fault_r |-> rx_data_out) else $error("receive output low during fault");
  a_therm_fault: assert property (@(posedge clk) disable iff (!rstn)
    thermal_shutdown [*6] |-> fault_r) else $error("thermal fault not indicated");
  a_therm_hiz: assert property (@(posedge clk) disable iff (!rstn)
    thermal_shutdown |-> !line_tx_oe) else $error("line driven in thermal shutdown");
  a_iso_low_down: assert property (@(posedge clk) disable iff (!rstn)
    iso_supply_low |=> link_r == irl_pkg::IRL_DOWN ##0 !line_tx_oe) else $error("link up with low supply");
  a_start_wait: assert property (@(posedge clk) disable iff (!rstn)
    $rose(link_r == irl_pkg::IRL_UP) |-> $past(start_cnt_r) == irl_pkg::CNT_W'(irl_pkg::START_CYC - 1))
    else $error("link resumed early");
  a_tof_time: assert property (@(posedge clk) disable iff (!rstn)
    rx_dly[1] ##1 (!rx_dly[1]) [*8] |-> !timeout) else $error("time-out too early");
  a_tof_fault: assert property (@(posedge clk) disable iff (!rstn)
    timeout |-> ##[0:THERM_WAIT] fault_r) else $error("time-out not indicated");
  a_weak_level: assert property (@(posedge clk) disable iff (!rstn)
    rx_out_gate_n_fault_oe && rx_out_gate_n_fault_out == fault_r) else $error("gate pin level wrong");

  c_link_up: cover property (@(posedge clk) disable iff (!rstn) $rose(link_r == irl_pkg::IRL_UP));
  c_line_drive: cover property (@(posedge clk) disable iff (!rstn) line_tx_oe && !line_tx_out);
  c_timeout: cover property (@(posedge clk) disable iff (!rstn) $rose(timeout) && !src_any);
  c_rx_low: cover property (@(posedge clk) disable iff (!rstn) rx_data_oe && !rx_data_out);

endmodule

// ---- verilog/irl_pkg.sv ----
// Shared constants for the isolated line-transceiver control block.
package irl_pkg;

  // ----------------------------------------------------------------
  // Clock and sampler timing
  // ----------------------------------------------------------------
  // System clock period in ns (20 MHz).
  localparam int CLK_PERIOD_NS = 50;
  // Internal sampler period in ns (4 MHz nominal).
  localparam int SAMPLE_PERIOD_NS = 250;
  // Clocks per sampler tick.
  localparam int SAMPLE_DIV = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  // Sampler counter width and last count.
  localparam int SAMPLE_CW = 3;
  localparam logic [SAMPLE_CW-1:0] SAMPLE_LAST = SAMPLE_CW'(SAMPLE_DIV - 1);
  // Isolated-side tick offset, so both sides never act on one edge.
  localparam logic [SAMPLE_CW-1:0] ISO_PHASE = 3'h2;

  // ----------------------------------------------------------------
  // Barrier delays and fault timing
  // ----------------------------------------------------------------
  // Nominal data delay across the barrier in ns, rounded down to cycles.
  localparam int DATA_DLY_NS = 600;
  localparam int DATA_DLY_CYC = DATA_DLY_NS / CLK_PERIOD_NS;
  // Nominal enable delay in ns; the part beyond the data delay is extra.
  localparam int DE_DLY_NS = 875;
  localparam int DE_EXTRA_CYC = (DE_DLY_NS - DATA_DLY_NS) / CLK_PERIOD_NS;
  // Register stages between the host sample and the transmit delay line.
  localparam int TX_PIPE_CYC = 2;
  // Transmit delay-line depth. The nominal delay counts from an average input edge, which waits
  // about half a sampler period for its tick, so that wait and the pipeline come off the line.
  localparam int TX_DLY_CYC = DATA_DLY_CYC - TX_PIPE_CYC - SAMPLE_DIV / 2;
  // Time-out after frames stop, in ns and cycles.
  localparam int TOF_NS = 1200;
  localparam int TOF_CYC = TOF_NS / CLK_PERIOD_NS;
  // Least start-up time after a fault clears, rounded up to cycles.
  localparam int START_NS = 1000;
  localparam int START_CYC = (START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Counter width for time-out and start-up counting.
  localparam int CNT_W = 6;

  // ----------------------------------------------------------------
  // Frame buffer and reset levels
  // ----------------------------------------------------------------
  // Transmit frame width ({enable, data}) and buffer depth.
  localparam int FRAME_W = 2;
  localparam int FIFO_DEPTH = 4;
  // Idle line level: a released receive line reads high.
  localparam logic LINE_IDLE = 1'b1;

  // Barrier link states.
  typedef enum logic [1:0] {
    IRL_DOWN,
    IRL_START,
    IRL_UP
  } irl_link_t;

endpackage

// ---- verilog/irl_fifo.sv ----
// Small synchronous FIFO carrying transmit frames across the barrier model.
`timescale 1ns/1ps
module irl_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);
  // Entry array.
  logic [WIDTH-1:0] mem_r [DEPTH];
  // Pointers carry one extra bit to tell full from empty.
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit.
  assign in_ready = !((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
  // Empty when pointers match.
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Write side; entries need no reset because pointers guard them.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointer update; flush drops stale frames when the link falls.
  always_ff @(posedge clk) begin
    if (!rstn || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule

// ---- verilog/irl_dly.sv ----
// Fixed-length register delay line used for barrier latency.
`timescale 1ns/1ps
module irl_dly #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 1,
  parameter logic [WIDTH-1:0] RST = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Data in and out.
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ----------------------------------------------------------------
  // Stage chain
  // ----------------------------------------------------------------
  // Stage 0 takes the input; the last stage drives the output.
  logic [WIDTH-1:0] stage_r [DEPTH];
  assign dout = stage_r[DEPTH-1];

  // One register per stage, each reset to the idle value.
  for (genvar i = 0; i < DEPTH; i++) begin : g_stage
    // The first stage reads the input itself, so no stage has a second driver.
    if (i == 0) begin : g_first
      always_ff @(posedge clk) begin
        if (!rstn) begin
          stage_r[i] <= RST;
        end else begin
          stage_r[i] <= din;
        end
      end
    end else begin : g_next
      always_ff @(posedge clk) begin
        if (!rstn) begin
          stage_r[i] <= RST;
        end else begin
          stage_r[i] <= stage_r[i-1];
        end
      end
    end
  end

endmodule

// ---- verif/irl_node_model.sv ----
// Remote line node model facing the isolated side of the transceiver.
`timescale 1ns/1ps
module irl_node_model (
  // Clock.
  input wire logic clk,
  // Bench control of this node.
  input wire logic node_drive,
  input wire logic node_level,
  // Pair driven by the transceiver.
  input wire logic line_tx_out,
  input wire logic line_tx_oe,
  // Pair towards the transceiver.
  output logic line_rx_in,
  output logic line_rx_open_short,
  output logic line_seen
);
  // ----------------------------------------------------------------
  // Released-pair filler
  // ----------------------------------------------------------------
  // Filler level that changes every cycle, so a released pair never looks stable.
  logic flip_r = 1'b0;

  // Advance the filler on every clock.
  always_ff @(posedge clk) begin
    flip_r <= ~flip_r;
  end

  // ----------------------------------------------------------------
  // Line levels
  // ----------------------------------------------------------------
  // A released pair raises the open flag and carries only the filler.
  assign line_rx_in = node_drive ? node_level : flip_r;
  assign line_rx_open_short = ~node_drive;
  // What this node sees: the transceiver level, or the filler once it lets go.
  assign line_seen = line_tx_oe ? line_tx_out : flip_r;
endmodule

// ---- verif/irl_link_ctrl_test.sv ----
// Self-checking testbench of the isolated line-transceiver control block.
`timescale 1ns/1ps
module irl_link_ctrl_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Clock, reset and host pins.
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic tx_data_in = 1'b1;
  logic tx_drive_enable = 1'b0;
  logic gate_host_oe = 1'b0;
  logic gate_host_val = 1'b0;
  logic gate_in;
  logic gate_out, gate_oe, rx_data_out, rx_data_oe;
  // Isolated side and fault sources (host, iso, thermal, barrier).
  logic isolated_rx_copy, line_tx_out, line_tx_oe, line_slow_slew;
  logic edge_rate_sel_n = 1'b1;
  logic line_rx_in, line_rx_open_short, line_seen;
  logic [3:0] fault_src = 4'h0;
  logic node_drive = 1'b1;
  logic node_level = 1'b1;
  // Counters of the run.
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;

  // Strong host drive wins over the weak fault level on the gate pin.
  // With nobody driving, the pin shows the opposite level, so a missing weak drive is caught.
  assign gate_in = gate_host_oe ? gate_host_val : (gate_oe ? gate_out : ~gate_out);

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  irl_link_ctrl i_dut (
    .clk(clk), .rstn(rstn), .tx_data_in(tx_data_in), .tx_drive_enable(tx_drive_enable),
    .rx_out_gate_n_fault_in(gate_in), .rx_out_gate_n_fault_out(gate_out),
    .rx_out_gate_n_fault_oe(gate_oe), .rx_data_out(rx_data_out), .rx_data_oe(rx_data_oe),
    .isolated_rx_copy(isolated_rx_copy), .edge_rate_sel_n(edge_rate_sel_n),
    .line_tx_out(line_tx_out), .line_tx_oe(line_tx_oe), .line_slow_slew(line_slow_slew),
    .line_rx_in(line_rx_in), .line_rx_open_short(line_rx_open_short),
    .host_supply_low(fault_src[0]), .iso_supply_low(fault_src[1]),
    .thermal_shutdown(fault_src[2]), .barrier_fail(fault_src[3]));

  irl_node_model i_node (
    .clk(clk), .node_drive(node_drive), .node_level(node_level),
    .line_tx_out(line_tx_out), .line_tx_oe(line_tx_oe), .line_rx_in(line_rx_in),
    .line_rx_open_short(line_rx_open_short), .line_seen(line_seen));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  // Free-running 20 MHz clock.
  initial begin
    forever #25 clk = ~clk;
  end

  // A run far beyond the expected length counts as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Let k falling edges pass.
  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask

  // Host transmit pins, changed at a falling edge.
  task automatic drive_tx(input logic en, input logic d);
    @(negedge clk);
    tx_drive_enable = en;
    tx_data_in = d;
  endtask

  // Host strong drive of the gate pin; oe low releases it.
  task automatic drive_gate(input logic oe, input logic v);
    @(negedge clk);
    gate_host_oe = oe;
    gate_host_val = v;
  endtask

  // Remote node drive; drv low leaves the pair open.
  task automatic drive_node(input logic drv, input logic v);
    @(negedge clk);
    node_drive = drv;
    node_level = v;
  endtask

  // Count cycles until the weak fault level reaches exp, bounded by max.
  task automatic wait_fault(input logic exp, input int max, output int k);
    k = 0;
    while (gate_out !== exp && k < max) begin
      @(negedge clk);
      k++;
    end
  endtask

  // Compare one output bit.
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compare a measured cycle count with its allowed window.
  task automatic cmp_range(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Reset, then transmit, slew, receive and every fault source in turn.
  initial begin
    idle(10);
    rstn = 1'b1;
    // Start-up: the weak gate level falls once the link is up.
    wait_fault(1'b0, 100, n);
    cmp_range(n, 20, 60);
    cmp_bit(rx_data_oe, 1'b1);
    $display("test startup done");
    // Transmit level, data delay and enable delay.
    drive_tx(1'b1, 1'b0);
    idle(30);
    cmp_bit(line_tx_oe, 1'b1);
    cmp_bit(line_seen, 1'b0);
    drive_tx(1'b1, 1'b1);
    idle(10);
    cmp_bit(line_seen, 1'b0);
    idle(5);
    cmp_bit(line_seen, 1'b1);
    drive_tx(1'b0, 1'b1);
    idle(14);
    cmp_bit(line_tx_oe, 1'b1);
    idle(6);
    cmp_bit(line_tx_oe, 1'b0);
    drive_tx(1'b1, 1'b1);
    $display("test transmit done");
    // Edge-rate select, low then high.
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      edge_rate_sel_n = i[0];
      idle(3);
      cmp_bit(line_slow_slew, ~i[0]);
    end
    $display("test slew done");
    // Receive path with the gate high, then low, then an open pair.
    drive_gate(1'b1, 1'b1);
    drive_node(1'b1, 1'b0);
    idle(3);
    cmp_bit(isolated_rx_copy, 1'b0);
    cmp_bit(rx_data_oe, 1'b0);
    drive_gate(1'b1, 1'b0);
    idle(25);
    cmp_bit(rx_data_oe, 1'b1);
    cmp_bit(rx_data_out, 1'b0);
    drive_node(1'b0, 1'b0);
    idle(25);
    cmp_bit(rx_data_out, 1'b1);
    cmp_bit(isolated_rx_copy, 1'b1);
    cmp_bit(gate_out, 1'b0);
    drive_node(1'b1, 1'b0);
    idle(22);
    // host polls the released gate pin with no fault
    drive_gate(1'b0, 1'b0);
    idle(1);
    cmp_bit(gate_in, 1'b0);
    cmp_bit(rx_data_oe, 1'b1);
    cmp_bit(rx_data_out, 1'b0);
    drive_gate(1'b1, 1'b0);
    $display("test receive done");
    // Each fault source: raise, poll the gate pin, clear, recover.
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      fault_src[k] = 1'b1;
      wait_fault(1'b1, 60, n);
      if (k == 3) begin
        cmp_range(n, 24, 50);
      end else begin
        cmp_range(n, 0, 7);
      end
      cmp_bit(rx_data_out, 1'b1);
      cmp_bit(line_tx_oe, 1'b0);
      cmp_bit(isolated_rx_copy, 1'b0);
      // host lets go of the gate pin before reading it
      drive_gate(1'b0, 1'b0);
      idle(1);
      cmp_bit(gate_in, 1'b1);
      cmp_bit(rx_data_oe, 1'b0);
      drive_gate(1'b1, 1'b0);
      @(negedge clk);
      fault_src[k] = 1'b0;
      idle(5);
      cmp_bit(gate_out, 1'b1);
      wait_fault(1'b0, 60, n);
      cmp_range(n, 15, 45);
      idle(30);
      cmp_bit(rx_data_out, 1'b0);
      cmp_bit(line_tx_oe, 1'b1);
      $display("test fault source %0d done", k);
    end
    summarize();
  end
endmodule
